// >>> tccu_pkg.sv
package tccu_pkg;
   // -------------------------------------------------------------
   // register byte offsets
   // -------------------------------------------------------------
   localparam logic [7:0] TCCU_OFF_ENABLE = 8'h00;
   localparam logic [7:0] TCCU_OFF_RUN = 8'h04;
   localparam logic [7:0] TCCU_OFF_CTRL = 8'h08;
   localparam logic [7:0] TCCU_OFF_MODE = 8'h0C;
   localparam logic [7:0] TCCU_OFF_FFCR = 8'h10;
   localparam logic [7:0] TCCU_OFF_MASK = 8'h14;
   localparam logic [7:0] TCCU_OFF_CMP0 = 8'h1C;
   localparam logic [7:0] TCCU_OFF_CMP1 = 8'h20;
   localparam logic [7:0] TCCU_OFF_LIVE = 8'h24;
   localparam logic [7:0] TCCU_OFF_CAP0 = 8'h28;
   localparam logic [7:0] TCCU_OFF_CAP1 = 8'h2C;
   localparam logic [7:0] TCCU_OFF_DMA = 8'h30;

   // -------------------------------------------------------------
   // field positions
   // -------------------------------------------------------------
   localparam int TCCU_BIT_CHAN_EN = 7;
   localparam int TCCU_BIT_CRUN = 0;
   localparam int TCCU_BIT_PRUN = 2;
   localparam int TCCU_BIT_WBF = 7;
   localparam int TCCU_POS_CLKSEL = 0;
   localparam int TCCU_POS_CPM = 3;
   localparam int TCCU_BIT_CLE = 5;
   localparam int TCCU_BIT_SWCAP = 6;
   localparam int TCCU_POS_FFCMD = 0;
   localparam int TCCU_POS_FFEN = 2;
   localparam int TCCU_BIT_DMA_CAP0 = 0;
   localparam int TCCU_BIT_DMA_CAP1 = 1;
   localparam int TCCU_BIT_DMA_MATCH1 = 2;
   localparam int TCCU_BIT_MASK_M0 = 0;
   localparam int TCCU_BIT_MASK_M1 = 1;
   localparam int TCCU_BIT_MASK_OVF = 2;

   // -------------------------------------------------------------
   // encodings and reset values
   // -------------------------------------------------------------
   localparam logic [2:0] TCCU_CLK_PIN = 3'h0;
   localparam logic [1:0] TCCU_CPM_OFF = 2'h0;
   localparam logic [1:0] TCCU_CPM_PIN_BOTH = 2'h1;
   localparam logic [1:0] TCCU_CPM_MATCH = 2'h2;
   localparam logic [1:0] TCCU_CPM_PIN_RISE = 2'h3;
   localparam logic [1:0] TCCU_FF_TOGGLE = 2'h0;
   localparam logic [1:0] TCCU_FF_SET = 2'h1;
   localparam logic [1:0] TCCU_FF_CLEAR = 2'h2;
   localparam logic [1:0] TCCU_FF_KEEP = 2'h3;
   localparam logic [15:0] TCCU_CNT_ZERO = 16'h0000;
   localparam logic [15:0] TCCU_CNT_MAX = 16'hFFFF;
   localparam logic [31:0] TCCU_RD_ZERO = 32'h0000_0000;
   // prescaler tap masks, index = clock select code (code 0 is the pin)
   localparam logic [7:0] TCCU_DIV_MASK [8] =
      '{8'h00, 8'h00, 8'h03, 8'h0F, 8'h1F, 8'h3F, 8'h7F, 8'hFF};
endpackage

// >>> tccu_prescaler.sv
`timescale 1ns/1ps
module tccu_prescaler
   import tccu_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic run,
   input wire logic [2:0] sel,
   output logic tick
);
   logic [7:0] div_r;
   logic tick_r;

   // -------------------------------------------------------------
   // free divider, held at zero while stopped
   // -------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         div_r <= 8'h00;
      else if (!run)
         div_r <= 8'h00;
      else
         div_r <= div_r + 8'h01;
   end

   // one-cycle tick at the selected tap
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         tick_r <= 1'b0;
      else
         tick_r <= run && (sel != TCCU_CLK_PIN)
                   && ((div_r & TCCU_DIV_MASK[sel]) == TCCU_DIV_MASK[sel]);
   end

   assign tick = tick_r;
endmodule // tccu_prescaler

// >>> tccu_pin_sync.sv
`timescale 1ns/1ps
module tccu_pin_sync
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic pin,
   output logic rise,
   output logic fall
);
   logic meta_r;
   logic sync_r;
   logic last_r;
   logic rise_r;
   logic fall_r;

   // -------------------------------------------------------------
   // two-stage synchroniser; only sync_r feeds the edge logic
   // -------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta_r <= 1'b0;
         sync_r <= 1'b0;
         last_r <= 1'b0;
      end
      else
      begin
         meta_r <= pin;
         sync_r <= meta_r;
         last_r <= sync_r;
      end
   end

   // edge pulses, one clock each
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rise_r <= 1'b0;
         fall_r <= 1'b0;
      end
      else
      begin
         rise_r <= sync_r & ~last_r;
         fall_r <= ~sync_r & last_r;
      end
   end

   assign rise = rise_r;
   assign fall = fall_r;
endmodule // tccu_pin_sync

// >>> tccu_timer.sv
// Summary of operation
// - clearing counter run stops the up counter and zeroes it at once
// - an up counter overflow raises the timer interrupt
// - two compare registers, each matched against the up counter
// - each compare has a buffer; double buffering off at reset, set by bit
// - buffered values load into both compares on a compare 1 match
// - while stopped, compare writes go straight in
// - capture mode field picks when counts latch into capture 0 and 1
// - writing 0 to software capture copies the count into capture 0
// - live count read snapshots while running; snapshot held while stopped
// - a match on either compare raises the timer interrupt
// - output flip-flop toggles on matches and captures, each enabled apart
// - flip-flop command 00 toggles, 01 sets, 10 clears
// - each capture raises its own capture interrupt
// - compare 1 match or capture interrupts issue a DMA request when enabled
// - compare 1 DMA request suppressed while its mask bit is set
// - event mode counts rising edges of the timer input pin
// - clear on match zeroes the counter on a compare 1 match
// - DMA enable bit 2 compare 1, bit 1 capture 1, bit 0 capture 0
`timescale 1ns/1ps
module tccu_timer
   import tccu_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic timer_input_pin,
   output logic timer_output_pin,
   output logic timer_interrupt,
   output logic capture_interrupt_0,
   output logic capture_interrupt_1,
   output logic dma_request
);
   import tccu_pkg::*;

   logic chan_en_r;
   logic counter_run_r;
   logic prescaler_run_r;
   logic buffer_en_r;
   logic [2:0] clk_sel_r;
   logic [1:0] cap_mode_r;
   logic clear_on_match_r;
   logic [3:0] ff_en_r;
   logic [2:0] mask_r;
   logic [2:0] dma_en_r;
   logic [15:0] cmp0_r;
   logic [15:0] cmp1_r;
   logic [15:0] buf0_r;
   logic [15:0] buf1_r;
   logic [15:0] cnt_r;
   logic [15:0] snap_r;
   logic [15:0] cap0_r;
   logic [15:0] cap1_r;
   logic ff_r;
   logic tint_r;
   logic cint0_r;
   logic cint1_r;
   logic dma_r;
   logic [31:0] prdata_r;
   logic [31:0] prdata_nxt;
   logic pready_r;
   logic pslverr_r;
   logic pslverr_nxt;

   logic setup;
   logic wr;
   logic running;
   logic pre_tick;
   logic pin_rise;
   logic pin_fall;
   logic tick;
   logic hit0;
   logic hit1;
   logic ovf;
   logic sw_cap;
   logic cap0_evt;
   logic cap1_evt;
   logic [1:0] ff_cmd;

   // -------------------------------------------------------------
   // clock sources
   // -------------------------------------------------------------
   tccu_prescaler u_pre (
      .clk(clk),
      .rst_n(rst_n),
      .run(prescaler_run_r & chan_en_r),
      .sel(clk_sel_r),
      .tick(pre_tick)
   );

   // pin is asynchronous, so it is synchronised before edge detection
   tccu_pin_sync u_pin (
      .clk(clk),
      .rst_n(rst_n),
      .pin(timer_input_pin),
      .rise(pin_rise),
      .fall(pin_fall)
   );

   // -------------------------------------------------------------
   // event decode
   // -------------------------------------------------------------
   // both run bits are needed; counter run alone gates the clear
   assign running = chan_en_r & counter_run_r & prescaler_run_r;
   assign tick = running & ((clk_sel_r == TCCU_CLK_PIN) ? pin_rise : pre_tick);
   assign hit0 = tick & (cnt_r == cmp0_r);
   assign hit1 = tick & (cnt_r == cmp1_r);
   assign ovf = tick & (cnt_r == TCCU_CNT_MAX) & ~(clear_on_match_r & hit1);

   // apb: answer is registered in the setup cycle, so every access has no wait state
   assign setup = psel & ~penable;
   assign wr = psel & penable & pwrite & pready_r;
   assign sw_cap = wr & (paddr == TCCU_OFF_MODE) & ~pwdata[TCCU_BIT_SWCAP];
   assign ff_cmd = pwdata[TCCU_POS_FFCMD +: 2];

   // capture strobes by mode; the software capture lands in capture 0
   always_comb
   begin
      cap0_evt = sw_cap;
      cap1_evt = 1'b0;
      case (cap_mode_r)
         TCCU_CPM_PIN_BOTH:
         begin
            cap0_evt = sw_cap | (running & pin_rise);
            cap1_evt = running & pin_fall;
         end
         TCCU_CPM_MATCH:
         begin
            cap0_evt = sw_cap | hit0;
            cap1_evt = hit1;
         end
         TCCU_CPM_PIN_RISE:
            cap0_evt = sw_cap | (running & pin_rise);
         default:
            cap0_evt = sw_cap;
      endcase
   end

   // -------------------------------------------------------------
   // control registers
   // -------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         chan_en_r <= 1'b0;
         counter_run_r <= 1'b0;
         prescaler_run_r <= 1'b0;
         buffer_en_r <= 1'b0;
         clk_sel_r <= TCCU_CLK_PIN;
         cap_mode_r <= TCCU_CPM_OFF;
         clear_on_match_r <= 1'b0;
         ff_en_r <= 4'h0;
         mask_r <= 3'h0;
         dma_en_r <= 3'h0;
      end
      else if (wr)
      begin
         case (paddr)
            TCCU_OFF_ENABLE: chan_en_r <= pwdata[TCCU_BIT_CHAN_EN];
            TCCU_OFF_RUN:
            begin
               counter_run_r <= pwdata[TCCU_BIT_CRUN];
               prescaler_run_r <= pwdata[TCCU_BIT_PRUN];
            end
            TCCU_OFF_CTRL: buffer_en_r <= pwdata[TCCU_BIT_WBF];
            TCCU_OFF_MODE:
            begin
               clk_sel_r <= pwdata[TCCU_POS_CLKSEL +: 3];
               cap_mode_r <= pwdata[TCCU_POS_CPM +: 2];
               clear_on_match_r <= pwdata[TCCU_BIT_CLE];
            end
            TCCU_OFF_FFCR: ff_en_r <= pwdata[TCCU_POS_FFEN +: 4];
            TCCU_OFF_MASK: mask_r <= pwdata[2:0];
            TCCU_OFF_DMA: dma_en_r <= pwdata[2:0];
            default: chan_en_r <= chan_en_r;
         endcase
      end
   end

   // -------------------------------------------------------------
   // up counter
   // -------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         cnt_r <= TCCU_CNT_ZERO;
      else if (!counter_run_r)
         cnt_r <= TCCU_CNT_ZERO;
      else if (clear_on_match_r && hit1)
         cnt_r <= TCCU_CNT_ZERO;
      else if (tick)
         cnt_r <= cnt_r + 16'h0001;
   end

   // -------------------------------------------------------------
   // compare registers and their buffers
   // -------------------------------------------------------------
   // buffers track every write so a later stop/start sees fresh values
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         buf0_r <= TCCU_CNT_ZERO;
         buf1_r <= TCCU_CNT_ZERO;
      end
      else if (wr)
      begin
         if (paddr == TCCU_OFF_CMP0)
            buf0_r <= pwdata[15:0];
         if (paddr == TCCU_OFF_CMP1)
            buf1_r <= pwdata[15:0];
      end
   end

   // direct write when single buffered or stopped; reload on match 1
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cmp0_r <= TCCU_CNT_ZERO;
         cmp1_r <= TCCU_CNT_ZERO;
      end
      else
      begin
         if (buffer_en_r && running && hit1)
         begin
            cmp0_r <= buf0_r;
            cmp1_r <= buf1_r;
         end
         if (wr && !(buffer_en_r && running))
         begin
            if (paddr == TCCU_OFF_CMP0)
               cmp0_r <= pwdata[15:0];
            if (paddr == TCCU_OFF_CMP1)
               cmp1_r <= pwdata[15:0];
         end
      end
   end

   // -------------------------------------------------------------
   // capture registers and live count snapshot
   // -------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cap0_r <= TCCU_CNT_ZERO;
         cap1_r <= TCCU_CNT_ZERO;
      end
      else
      begin
         if (cap0_evt)
            cap0_r <= cnt_r;
         if (cap1_evt)
            cap1_r <= cnt_r;
      end
   end

   // snapshot taken in the setup cycle of a read while running
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         snap_r <= TCCU_CNT_ZERO;
      else if (setup && !pwrite && paddr == TCCU_OFF_LIVE && running)
         snap_r <= cnt_r;
   end

   // -------------------------------------------------------------
   // output flip-flop
   // -------------------------------------------------------------
   // a software command wins over a same-cycle hardware toggle
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         ff_r <= 1'b0;
      else if (wr && paddr == TCCU_OFF_FFCR && ff_cmd == TCCU_FF_TOGGLE)
         ff_r <= ~ff_r;
      else if (wr && paddr == TCCU_OFF_FFCR && ff_cmd == TCCU_FF_SET)
         ff_r <= 1'b1;
      else if (wr && paddr == TCCU_OFF_FFCR && ff_cmd == TCCU_FF_CLEAR)
         ff_r <= 1'b0;
      else
         ff_r <= ff_r ^ (^{ff_en_r[0] & hit0, ff_en_r[1] & hit1,
                            ff_en_r[2] & cap0_evt, ff_en_r[3] & cap1_evt});
   end

   // -------------------------------------------------------------
   // interrupt and dma pulses
   // -------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tint_r <= 1'b0;
         cint0_r <= 1'b0;
         cint1_r <= 1'b0;
         dma_r <= 1'b0;
      end
      else
      begin
         tint_r <= (hit0 & ~mask_r[TCCU_BIT_MASK_M0])
                   | (hit1 & ~mask_r[TCCU_BIT_MASK_M1])
                   | (ovf & ~mask_r[TCCU_BIT_MASK_OVF]);
         cint0_r <= cap0_evt;
         cint1_r <= cap1_evt;
         dma_r <= (hit1 & dma_en_r[TCCU_BIT_DMA_MATCH1] & ~mask_r[TCCU_BIT_MASK_M1])
                  | (cap1_evt & dma_en_r[TCCU_BIT_DMA_CAP1])
                  | (cap0_evt & dma_en_r[TCCU_BIT_DMA_CAP0]);
      end
   end

   // -------------------------------------------------------------
   // apb read mux and answer
   // -------------------------------------------------------------
   always_comb
   begin
      prdata_nxt = TCCU_RD_ZERO;
      pslverr_nxt = 1'b0;
      case (paddr)
         TCCU_OFF_ENABLE: prdata_nxt[TCCU_BIT_CHAN_EN] = chan_en_r;
         TCCU_OFF_RUN:
         begin
            prdata_nxt[TCCU_BIT_CRUN] = counter_run_r;
            prdata_nxt[TCCU_BIT_PRUN] = prescaler_run_r;
         end
         TCCU_OFF_CTRL: prdata_nxt[TCCU_BIT_WBF] = buffer_en_r;
         TCCU_OFF_MODE:
         begin
            prdata_nxt[TCCU_POS_CLKSEL +: 3] = clk_sel_r;
            prdata_nxt[TCCU_POS_CPM +: 2] = cap_mode_r;
            prdata_nxt[TCCU_BIT_CLE] = clear_on_match_r;
            prdata_nxt[TCCU_BIT_SWCAP] = 1'b1;
         end
         TCCU_OFF_FFCR:
         begin
            prdata_nxt[TCCU_POS_FFCMD +: 2] = TCCU_FF_KEEP;
            prdata_nxt[TCCU_POS_FFEN +: 4] = ff_en_r;
         end
         TCCU_OFF_MASK: prdata_nxt[2:0] = mask_r;
         TCCU_OFF_CMP0: prdata_nxt[15:0] = cmp0_r;
         TCCU_OFF_CMP1: prdata_nxt[15:0] = cmp1_r;
         // running: the value being snapshotted now; stopped: the old one
         TCCU_OFF_LIVE: prdata_nxt[15:0] = running ? cnt_r : snap_r;
         TCCU_OFF_CAP0: prdata_nxt[15:0] = cap0_r;
         TCCU_OFF_CAP1: prdata_nxt[15:0] = cap1_r;
         TCCU_OFF_DMA: prdata_nxt[2:0] = dma_en_r;
         default: pslverr_nxt = 1'b1;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= TCCU_RD_ZERO;
      end
      else
      begin
         pready_r <= setup;
         pslverr_r <= setup & pslverr_nxt;
         if (setup && !pwrite)
            prdata_r <= prdata_nxt;
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign timer_output_pin = ff_r;
   assign timer_interrupt = tint_r;
   assign capture_interrupt_0 = cint0_r;
   assign capture_interrupt_1 = cint1_r;
   assign dma_request = dma_r;
endmodule // tccu_timer

// >>> tccu_timer_asserts.sv
`timescale 1ns/1ps
module tccu_timer_asserts
   import tccu_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic timer_output_pin,
   input wire logic timer_interrupt,
   input wire logic capture_interrupt_0,
   input wire logic capture_interrupt_1,
   input wire logic dma_request
);
   // ----
   // sequences
   // ----
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // any interrupt pulse; dma is raised in the same cycle as it
   wire any_irq = timer_interrupt | capture_interrupt_0 | capture_interrupt_1;
   // write accepted at this edge
   sequence s_wr(logic [7:0] a);
      psel && penable && pready && pwrite && paddr == a;
   endsequence
   // flip-flop command write
   sequence s_ff(logic [1:0] c);
      s_wr(TCCU_OFF_FFCR) ##0 pwdata[1:0] == c;
   endsequence
   // ----
   // properties
   // ----
   AST_PREADY_WAIT: assert property (psel && !penable |=> pready)
      else $error("pready late");
   AST_PREADY_PULSE: assert property (pready |=> !pready)
      else $error("pready held");
   AST_ERR_READ: assert property (pslverr |-> pready && (pwrite || prdata == TCCU_RD_ZERO))
      else $error("bad error response");
   AST_FF_SET: assert property (s_ff(TCCU_FF_SET) |=> timer_output_pin)
      else $error("ff not set");
   AST_FF_CLR: assert property (s_ff(TCCU_FF_CLEAR) |=> !timer_output_pin)
      else $error("ff not cleared");
   AST_FF_TGL: assert property (s_ff(TCCU_FF_TOGGLE) |=> $changed(timer_output_pin))
      else $error("ff not toggled");
   AST_SWCAP: assert property (s_wr(TCCU_OFF_MODE) ##0 !pwdata[TCCU_BIT_SWCAP]
      |-> ##[0:2] capture_interrupt_0) else $error("no capture pulse");
   AST_STOP: assert property (s_wr(TCCU_OFF_RUN) ##0 !pwdata[TCCU_BIT_CRUN]
      |-> ##2 !timer_interrupt [*8]) else $error("stopped timer interrupts");
   AST_DMA: assert property (dma_request |-> any_irq || $past(any_irq))
      else $error("dma without source");
endmodule // tccu_timer_asserts

bind tccu_timer tccu_timer_asserts chk_i (.clk(clk), .rst_n(rst_n), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .timer_output_pin(timer_output_pin),
   .timer_interrupt(timer_interrupt), .capture_interrupt_0(capture_interrupt_0),
   .capture_interrupt_1(capture_interrupt_1), .dma_request(dma_request));

// >>> tccu_pin_model.sv
`timescale 1ns/1ps
module tccu_pin_model
(
   input wire logic clk,
   input wire logic [7:0] pulses,
   input wire logic [3:0] width,
   input wire logic go,
   output logic pin
);
   int left;
   int ph;
   initial pin = 1'b0;
   // pulse train: width high, width low; idles low as if pulled down
   always @(posedge clk)
   begin
      if (go && left == 0)
      begin
         left <= pulses;
         ph <= 0;
      end
      else if (left != 0)
      begin
         pin <= (ph < width);
         ph <= (ph == 2 * width - 1) ? 0 : ph + 1;
         if (ph == 2 * width - 1)
            left <= left - 1;
      end
      else
         pin <= 1'b0;
   end
endmodule // tccu_pin_model

// >>> tccu_timer_tb.sv
`timescale 1ns/1ps
module tccu_timer_tb;
   import tccu_pkg::*;
   logic clk, rst_n, psel, penable, pwrite, go, e, pin, tout, ti, c0, c1, dma, pready, pslverr;
   logic [7:0] paddr, pulses;
   logic [3:0] width, w;
   logic [31:0] pwdata, prdata, q, x;
   logic [31:0] rs = 32'h0000_0020;
   logic [15:0] n1, n2, n3;
   int bad_count, comparisons, cyc, t0, last_t, prev_t;
   logic [7:0] adr [13] = '{TCCU_OFF_ENABLE, TCCU_OFF_RUN, TCCU_OFF_CTRL, TCCU_OFF_MODE,
      TCCU_OFF_FFCR, TCCU_OFF_MASK, TCCU_OFF_CMP0, TCCU_OFF_CMP1, TCCU_OFF_LIVE,
      TCCU_OFF_CAP0, TCCU_OFF_CAP1, TCCU_OFF_DMA, 8'h18};
   tccu_timer dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .timer_input_pin(pin), .timer_output_pin(tout), .timer_interrupt(ti),
      .capture_interrupt_0(c0), .capture_interrupt_1(c1), .dma_request(dma));
   tccu_pin_model peer (.clk(clk), .pulses(pulses), .width(width), .go(go), .pin(pin));
   // ----
   // helpers
   // ----
   function automatic logic [31:0] rnd();
      rs ^= rs << 13;
      rs ^= rs >> 17;
      rs ^= rs << 5;
      return rs;
   endfunction
   // reset image; mode and command fields read back as idle codes
   function automatic logic [31:0] rst_val(input logic [7:0] a);
      if (a == TCCU_OFF_MODE)
         return 32'h0000_0040;
      if (a == TCCU_OFF_FFCR)
         return 32'h0000_0003;
      return TCCU_RD_ZERO;
   endfunction
   function automatic logic [31:0] keep(input logic [7:0] a, input logic [31:0] d);
      return d & ((a == TCCU_OFF_DMA) ? 32'h0000_0007 : 32'h0000_FFFF);
   endfunction
   // interval with clear on match spans compare plus one ticks
   function automatic logic [31:0] per(input logic [15:0] c);
      return 32'(c) + 1;
   endfunction
   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      comparisons++;
      if (got !== ex)
      begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
      end
   endtask
   // one transfer; pready is registered, so the level before the edge is what it samples
   task automatic apb(input logic wt, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wt;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1 && ++n < 50);
      bad_count += int'(n >= 50);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] ex);
      apb(1'b0, a, TCCU_RD_ZERO);
      chk("rdata", ex, q);
   endtask
   task automatic wait_ti;
      int n;
      n = 0;
      do @(negedge clk); while (ti !== 1'b1 && ++n < 70000);
      bad_count += int'(n >= 70000);
      prev_t = last_t;
      last_t = cyc;
   endtask
   task automatic dma_cnt(input int len, output logic [31:0] k, input bit s = 1'b0);
      k = 0;
      repeat (len)
      begin
         @(negedge clk);
         k += 32'((s ? c1 : dma) === 1'b1);
      end
   endtask
   task automatic burst(input logic [7:0] n, input logic [3:0] wd);
      @(posedge clk);
      pulses <= n;
      width <= wd;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      repeat (2 * n * wd + 8) @(posedge clk);
   endtask
   task automatic summarize;
      $display("comparisons %0d bad_count %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // ----
   // clock, cycle count, watchdog
   // ----
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   always @(posedge clk) cyc <= cyc + 1;
   // overflow alone needs 65536 ticks, so allow about 80k cycles
   initial
   begin
      #8_000_000;
      bad_count++;
      summarize();
   end
   // ----
   // scenarios
   // ----
   initial
   begin
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = TCCU_RD_ZERO;
      go = 1'b0;
      pulses = 8'h00;
      width = 4'h2;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 13; i++)
      begin
         rd(adr[i], rst_val(adr[i]));
         chk("slverr", 32'(i == 12), 32'(e));
      end
      wr(8'h18, rnd());
      chk("slverr", 32'h0000_0001, 32'(e));
      // random readback while stopped
      for (int i = 0; i < 9; i++)
      begin
         x = rnd();
         wr(adr[6 + i % 3 + (i % 3 == 2) * 3], x);
         rd(adr[6 + i % 3 + (i % 3 == 2) * 3], keep(adr[6 + i % 3 + (i % 3 == 2) * 3], x));
      end
      // interval timing, match 0 masked
      n1 = 16'(rnd() % 16 + 12);
      wr(TCCU_OFF_ENABLE, 8'h80);
      wr(TCCU_OFF_FFCR, 8'h03);
      wr(TCCU_OFF_MODE, 8'h61);
      wr(TCCU_OFF_MASK, 8'h05);
      wr(TCCU_OFF_DMA, 8'h04);
      wr(TCCU_OFF_CMP1, 32'(n1));
      wr(TCCU_OFF_RUN, 8'h05);
      wait_ti;
      wait_ti;
      chk("period", per(n1), 32'(last_t - prev_t));
      dma_cnt(3 * (n1 + 1), x);
      chk("dma", 32'h0000_0003, x);
      wr(TCCU_OFF_MASK, 8'h07);
      dma_cnt(3 * (n1 + 1), x);
      chk("dma", TCCU_RD_ZERO, x);
      wr(TCCU_OFF_MASK, 8'h05);
      apb(1'b0, TCCU_OFF_LIVE, TCCU_RD_ZERO);
      x = q;
      chk("live", 32'h0000_0001, 32'(x <= 32'(n1)));
      wr(TCCU_OFF_RUN, 8'h00);
      rd(TCCU_OFF_LIVE, x);
      wr(TCCU_OFF_MODE, 8'h21);
      rd(TCCU_OFF_CAP0, TCCU_RD_ZERO);
      // flip-flop commands, then toggles on compare 1
      for (int i = 0; i < 3; i++)
      begin
         wr(TCCU_OFF_FFCR, 32'((4'h1 << i) & 4'h3));
         @(negedge clk);
         chk("ff", 32'(i != 1), 32'(tout));
      end
      wr(TCCU_OFF_FFCR, 8'h0A);
      wr(TCCU_OFF_RUN, 8'h05);
      for (int i = 1; i >= 0; i--)
      begin
         wait_ti;
         repeat (3) @(negedge clk);
         chk("ff", 32'(i), 32'(tout));
      end
      // double buffering
      wr(TCCU_OFF_RUN, 8'h00);
      wr(TCCU_OFF_FFCR, 8'h03);
      wr(TCCU_OFF_CTRL, 8'h80);
      n2 = n1 + 16'h0008;
      wr(TCCU_OFF_CMP1, 32'(n2));
      wr(TCCU_OFF_RUN, 8'h05);
      t0 = cyc;
      wait_ti;
      chk("start", 32'h0000_0001, 32'(last_t - t0 >= n2 && last_t - t0 <= n2 + 4));
      n3 = n2 + 16'h0014;
      wr(TCCU_OFF_CMP1, 32'(n3));
      wait_ti;
      chk("period", per(n2), 32'(last_t - prev_t));
      wait_ti;
      chk("period", per(n3), 32'(last_t - prev_t));
      // event counting read through a software capture
      pulses <= 8'(rnd() % 16 + 3);
      wr(TCCU_OFF_RUN, 8'h00);
      wr(TCCU_OFF_MODE, 8'h40);
      wr(TCCU_OFF_RUN, 8'h05);
      burst(pulses, 4'h2);
      wr(TCCU_OFF_MODE, 8'h00);
      rd(TCCU_OFF_CAP0, 32'(pulses));
      // pin edge capture, then match capture
      w = 4'(rnd() % 8 + 2);
      wr(TCCU_OFF_RUN, 8'h00);
      wr(TCCU_OFF_MODE, 8'h49);
      wr(TCCU_OFF_RUN, 8'h05);
      burst(8'h01, w);
      apb(1'b0, TCCU_OFF_CAP1, TCCU_RD_ZERO);
      x = q;
      apb(1'b0, TCCU_OFF_CAP0, TCCU_RD_ZERO);
      chk("width", 32'(w), x - q);
      n2 = 16'(rnd() % 20 + 5);
      wr(TCCU_OFF_RUN, 8'h00);
      wr(TCCU_OFF_CMP0, 32'(n2));
      wr(TCCU_OFF_CMP1, 32'(n2) + 20);
      wr(TCCU_OFF_MODE, 8'h51);
      wr(TCCU_OFF_RUN, 8'h05);
      dma_cnt(60, x, 1'b1);
      chk("cap1 irq", 32'h0000_0001, x);
      rd(TCCU_OFF_CAP0, 32'(n2));
      rd(TCCU_OFF_CAP1, 32'(n2) + 20);
      // overflow with matches masked
      wr(TCCU_OFF_RUN, 8'h00);
      wr(TCCU_OFF_MASK, 8'h03);
      wr(TCCU_OFF_MODE, 8'h41);
      wr(TCCU_OFF_RUN, 8'h05);
      t0 = cyc;
      wait_ti;
      chk("wrap", 32'h0000_0001, 32'(last_t - t0 >= 65536 && last_t - t0 <= 65541));
      summarize();
   end
endmodule // tccu_timer_tb
